/* common/plbc_defs.vh */
// Constants for the processor local bus control block
`ifndef PLBC_DEFS_VH
`define PLBC_DEFS_VH
// Clock control register fields (I/O port 1072H image)
`define PLBC_CLKCTL_DIR_BIT   3
`define PLBC_CLKCTL_DIV_MSB   2
`define PLBC_CLKCTL_DIV_LSB   0
`define PLBC_CLKCTL_RST       4'h0
// SMI enable bit position in port C472H image
`define PLBC_SMI_EN_BIT       13
// SMI processor modes
`define PLBC_SMIMODE_SEP      1'b0
`define PLBC_SMIMODE_SHARED   1'b1
// Default wait states before ready
`define PLBC_WAIT_DEF         4'h2
// Processor reset stretch, cycles
`define PLBC_RST_CYC          8'h10
`endif

/* tb/plbc_cpu_model.sv */
// Processor side of the hold handshake with a selectable grant delay
`timescale 1ns/1ps
module plbc_cpu_model (
  input  logic       clk,            // clock
  input  logic       arst_n,         // reset, active low
  input  logic       hold_req,       // hold request
  input  logic [2:0] grant_lat,      // cycles before grant
  output logic       bus_hold_grant  // hold grant
);
  logic [2:0] wait_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n || !hold_req) begin
      wait_ff <= 3'h0;
      bus_hold_grant <= 1'b0;
    end else if (wait_ff == grant_lat) bus_hold_grant <= 1'b1;
    else wait_ff <= wait_ff + 3'h1;
  end
endmodule // plbc_cpu_model

/* tb/plbc_top_props.sv */
// Port-level checker for the processor local bus control block
`timescale 1ns/1ps
module plbc_top_props (
  input logic        clk,                           // clock
  input logic        arst_n,                        // reset, active low
  input logic        pipeline_en,                   // next-address allowed
  input logic [15:0] smi_cfg,                       // SMI configuration
  input logic        smi_mode,                      // SMI ready mode
  input logic        snoop_en,                      // DMA line drive
  input logic        bus_hold_grant,                // hold grant
  input logic        irq_req,                       // interrupt source
  input logic        nmi_req,                       // NMI source
  input logic        channel_check_n,               // channel check
  input logic        ready_n_ff,                    // ready
  input logic        smi_cycle_done_n_ff,           // SMI ready
  input logic        pipeline_next_address_n_ff,    // next address
  input logic        bus_hold_request_ff,           // hold request
  input logic        cycle_start_strobe_oe_ff,      // strobe drive
  input logic        mem_io_oe_ff,                  // memory/IO drive
  input logic        maskable_interrupt_request_ff, // interrupt
  input logic        nmi_ff,                        // NMI
  input logic        processor_reset_ff             // processor reset
);
  logic [4:0] up_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Cycles since reset release, saturating
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n) up_ff <= 5'h00;
    else if (up_ff != 5'h1F) up_ff <= up_ff + 5'h01;
  a_ready_pulse: assert property (!ready_n_ff |=> ready_n_ff)
    else $error("ready held low");
  a_smi_ready_mode: assert property (!smi_cycle_done_n_ff |-> !smi_mode && smi_cfg[13])
    else $error("SMI ready in wrong mode");
  a_next_address: assert property (!pipeline_next_address_n_ff |->
    $past(pipeline_en) ##[0:16] !(ready_n_ff && smi_cycle_done_n_ff))
    else $error("stray next address");
  a_nmi_follow: assert property (nmi_ff == $past(nmi_req || !channel_check_n))
    else $error("NMI does not follow sources");
  a_irq_follow: assert property (maskable_interrupt_request_ff == $past(irq_req))
    else $error("interrupt does not follow source");
  a_drive_granted: assert property (mem_io_oe_ff || cycle_start_strobe_oe_ff |->
    $past(bus_hold_grant) && bus_hold_request_ff && $past(snoop_en)) else $error("drive w/o grant");
  a_release_first: assert property ($fell(bus_hold_request_ff) |->
    $past(!mem_io_oe_ff && !cycle_start_strobe_oe_ff)) else $error("hold dropped while driving");
  a_reset_stretch: assert property (up_ff < 5'h10 |-> processor_reset_ff)
    else $error("processor reset too short");
endmodule // plbc_top_props
bind plbc_top plbc_top_props i_props (.*);

/* tb/processor_local_bus_control_test.sv */
// Self-checking bench for the processor local bus control block
`timescale 1ns/1ps
module processor_local_bus_control_test;
  logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, local_ready = 1'b1, cpu_stb_n = 1'b1;
  logic cpu_mio = 1'b0, cpu_wr = 1'b0, cpu_ube_n = 1'b1, data_ctl_i = 1'b0, smi_mode = 1'b0;
  logic smi_space_strobe_n = 1'b1, pipeline_en = 1'b0, snoop_en = 1'b0, cached_cpu = 1'b0;
  logic dma_req = 1'b0, dma_mem = 1'b0, dma_write = 1'b0, dma_upper = 1'b0, irq_req = 1'b0;
  logic nmi_req = 1'b0, channel_check_n = 1'b1, sw_reset = 1'b0;
  logic [3:0]  wait_states = 4'h0, clk_ctl = 4'h0;
  logic [15:0] smi_cfg = 16'h0000;
  logic [2:0]  grant_lat = 3'h0;
  wire bus_hold_grant, cycle_start_strobe_n, mem_io_i, wr_rd_i, upper_byte_enable_n_i;
  wire ready_n_ff, smi_cycle_done_n_ff, pipeline_next_address_n_ff, bus_hold_request_ff;
  wire cycle_start_strobe_o_ff, cycle_start_strobe_oe_ff, mem_io_o_ff, mem_io_oe_ff, nmi_ff;
  wire wr_rd_o_ff, wr_rd_oe_ff, upper_byte_enable_o_ff, upper_byte_enable_oe_ff;
  wire maskable_interrupt_request_ff, processor_reset_ff, processor_clock_o, processor_clock_oe;
  wire cyc_mem_ff, cyc_write_ff, cyc_data_ff, cyc_upper_ff;
  int failures = 0, n_checks = 0, cyc = 0;
  logic [31:0] exp_q[$];
  // Released lines float: a toggling pattern while the processor is granted away
  assign cycle_start_strobe_n = cycle_start_strobe_oe_ff ? cycle_start_strobe_o_ff
                              : bus_hold_grant ? cyc[0] : cpu_stb_n;
  assign mem_io_i = mem_io_oe_ff ? mem_io_o_ff : bus_hold_grant ? cyc[0] : cpu_mio;
  assign wr_rd_i = wr_rd_oe_ff ? wr_rd_o_ff : bus_hold_grant ? cyc[0] : cpu_wr;
  assign upper_byte_enable_n_i = upper_byte_enable_oe_ff ? upper_byte_enable_o_ff
                               : bus_hold_grant ? cyc[0] : cpu_ube_n;
  plbc_top i_dut (.*);
  plbc_cpu_model i_cpu (.clk(clk), .arst_n(arst_n), .hold_req(bus_hold_request_ff),
                        .grant_lat(grant_lat), .bus_hold_grant(bus_hold_grant));
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (e !== g) begin
      failures++;
      $display("unexpected %s: expected %0h, seen %0h", what, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One processor cycle; strobe stays low while busy and must be ignored
  task automatic bus_cycle;
    logic [3:0] w;
    logic [4:0] q;
    w = 4'($urandom);
    q = 5'($urandom);
    smi_cfg = 16'($urandom);
    smi_mode = 1'($urandom);
    pipeline_en = 1'($urandom);
    {cpu_mio, cpu_wr, data_ctl_i, cpu_ube_n, smi_space_strobe_n} = q;
    wait_states = w;
    cpu_stb_n = 1'b0;
    @(negedge clk);
    exp_q.push_back({26'(cyc + w + 1), q[4:2], ~q[1], ~q[0] & smi_cfg[13] & ~smi_mode,
      pipeline_en});
    for (int i = 0; i < 40 && ready_n_ff && smi_cycle_done_n_ff; i++) @(negedge clk);
    cpu_stb_n = 1'b1;
    @(negedge clk);
  endtask
  always @(negedge clk) if (arst_n && !(ready_n_ff && smi_cycle_done_n_ff)) begin
    if (exp_q.size() == 0) chk("spare ready", 0, 1);
    else chk("ready", exp_q.pop_front(), {cyc[25:0], cyc_mem_ff, cyc_write_ff, cyc_data_ff,
      cyc_upper_ff, ~smi_cycle_done_n_ff, ~pipeline_next_address_n_ff});
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic v;
    int n;
    void'($urandom(61165));
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    repeat (10) @(negedge clk) chk("cpu reset", 1, processor_reset_ff);
    repeat (10) @(negedge clk);
    chk("cpu reset", 0, processor_reset_ff);
    sw_reset = 1'b1;
    repeat (2) @(negedge clk);
    chk("sw reset", 1, processor_reset_ff);
    sw_reset = 1'b0;
    repeat (20) @(negedge clk);
    repeat (30) bus_cycle();
    for (int k = 0; k < 8; k++) begin
      {snoop_en, cached_cpu} = 2'(k);
      {dma_mem, dma_write, dma_upper} = 3'($urandom);
      grant_lat = 3'($urandom);
      dma_req = 1'b1;
      @(negedge clk) chk("hold", 1, bus_hold_request_ff);
      repeat (10) @(negedge clk);
      chk("drive", {snoop_en, snoop_en, cached_cpu & dma_mem & dma_write, 1'b1}, {mem_io_oe_ff,
        cycle_start_strobe_oe_ff, wr_rd_oe_ff, upper_byte_enable_oe_ff});
      if (snoop_en) chk("mio", dma_mem, mem_io_i);
      if (snoop_en) chk("stb", 1'(~(dma_mem & dma_write)), cycle_start_strobe_n);
      if (cached_cpu & dma_mem & dma_write) chk("wr", 1, wr_rd_i);
      chk("ube", 1'(~dma_upper), upper_byte_enable_n_i);
      dma_req = 1'b0;
      repeat (3) @(negedge clk);
      chk("release", 0, {bus_hold_request_ff, mem_io_oe_ff, cycle_start_strobe_oe_ff,
        wr_rd_oe_ff, upper_byte_enable_oe_ff});
      repeat (3) @(negedge clk);
    end
    repeat (16) begin
      {irq_req, nmi_req, channel_check_n} = 3'($urandom);
      @(negedge clk) chk("irq nmi", {irq_req, nmi_req | ~channel_check_n},
        {maskable_interrupt_request_ff, nmi_ff});
    end
    clk_en = 1'b0;
    v = processor_clock_o;
    repeat (8) @(negedge clk) chk("freeze", v, processor_clock_o);
    clk_en = 1'b1;
    repeat (6) begin
      clk_ctl = 4'($urandom);
      repeat (40) @(negedge clk);
      chk("clk dir", 1'(~clk_ctl[3]), processor_clock_oe);
      repeat (2) begin
        v = processor_clock_o;
        for (n = 0; processor_clock_o === v && n < 20; n++) @(negedge clk);
      end
      if (!clk_ctl[3]) chk("clk half", clk_ctl[2:0] + 1, n);
    end
    chk("pending", 0, exp_q.size());
    conclude();
  end
  initial begin
    #(25 * 20000);
    failures++;
    conclude();
  end
endmodule // processor_local_bus_control_test

/* verilog/plbc_clk_gen.v */
// Processor clock divider with direction control
`timescale 1ns/1ps
`include "plbc_defs.vh"
module plbc_clk_gen (
  input  wire       clk,        // System clock
  input  wire       arst_n,     // Async reset, active low
  input  wire       clk_en,     // Clock enable
  input  wire [3:0] clk_ctl,    // Clock control register image
  output reg        pclk_o_ff,  // Processor clock out
  output reg        pclk_oe_ff  // Processor clock drive enable
);
  reg [7:0] cnt_ff;
  wire [2:0] div = clk_ctl[`PLBC_CLKCTL_DIV_MSB:`PLBC_CLKCTL_DIV_LSB];
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff     <= 8'h00;
      pclk_o_ff  <= 1'b0;
      pclk_oe_ff <= 1'b0;
    end else if (clk_en) begin
      pclk_oe_ff <= ~clk_ctl[`PLBC_CLKCTL_DIR_BIT]; // R14
      if (cnt_ff >= {5'h00, div}) begin
        cnt_ff    <= 8'h00;
        pclk_o_ff <= ~pclk_o_ff; // R14
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule // plbc_clk_gen

/* verilog/plbc_top.v */
// Processor local bus control: cycles, ready, hold, interrupts, reset
// Function
// R1 - Processor marks upper byte with enable; device drives it during DMA.
// R2 - Dedicated SMI ready returned per selected SMI processor mode.
// R3 - Processor drives data/control status for current cycle.
// R4 - Memory/IO line high for memory, low for I/O.
// R5 - When enabled, device drives memory/IO and strobe during DMA cycles.
// R6 - Every cycle starts on the processor address strobe only.
// R7 - Processor flags SMI space cycles with SMI strobe.
// R8 - Write/read line high for write, low for read.
// R9 - Cached processor: device drives write/read on DMA memory writes.
// R10 - Ready output marks completion of current cycle.
// R11 - Without separate SMI ready, normal ready completes SMI cycles too.
// R12 - Hold request asserted when device needs the local bus.
// R13 - Processor grants bus by hold acknowledge.
// R14 - Processor clock speed and direction follow clock control register.
// R15 - Non-maskable interrupt output provided.
// R16 - Next-address asserted to allow pipelined cycles.
// R17 - Maskable interrupt output provided.
// R18 - Processor reset generated synchronously with the clock.
// R19 - SMI operation enabled by bit 13 of SMI configuration word.
// R20 - Channel check raises non-maskable interrupt.
// R21 - Drive DMA cycle lines only after grant; release before dropping request.
`timescale 1ns/1ps
`include "plbc_defs.vh"
module plbc_top #(
  parameter WAIT_W = 4                      // Wait-state counter width
) (
  input  wire        clk,                   // 40 MHz clock
  input  wire        arst_n,                // Async reset, active low
  input  wire        clk_en,                // Clock enable
  input  wire        cycle_start_strobe_n,  // Processor address strobe in
  input  wire        mem_io_i,              // Memory/IO in
  input  wire        wr_rd_i,               // Write/read in
  input  wire        data_ctl_i,            // Data/control status in
  input  wire        upper_byte_enable_n_i, // Upper byte enable in
  input  wire        smi_space_strobe_n,    // SMI space strobe in
  input  wire        local_ready,           // Addressed target is ready
  input  wire [WAIT_W-1:0] wait_states,     // Wait states before ready
  input  wire        pipeline_en,           // Allow next-address
  input  wire [15:0] smi_cfg,               // SMI configuration word
  input  wire        smi_mode,              // Separate or shared SMI ready
  input  wire [3:0]  clk_ctl,               // Clock control register image
  input  wire        snoop_en,              // Drive memory/IO and strobe during DMA
  input  wire        cached_cpu,            // Processor has internal cache
  input  wire        dma_req,               // DMA/master wants the bus
  input  wire        dma_mem,               // DMA cycle is memory
  input  wire        dma_write,             // DMA cycle is write
  input  wire        dma_upper,             // DMA cycle uses upper byte
  input  wire        bus_hold_grant,        // Hold acknowledge
  input  wire        irq_req,               // Maskable interrupt source
  input  wire        nmi_req,               // Non-maskable interrupt source
  input  wire        channel_check_n,       // Expansion channel check
  input  wire        sw_reset,              // Processor reset request
  output reg         ready_n_ff,            // Processor ready
  output reg         smi_cycle_done_n_ff,   // SMI ready
  output reg         pipeline_next_address_n_ff, // Next address
  output reg         bus_hold_request_ff,   // Hold request
  output reg         cycle_start_strobe_o_ff,  // Strobe drive value
  output reg         cycle_start_strobe_oe_ff, // Strobe drive enable
  output reg         mem_io_o_ff,           // Memory/IO drive value
  output reg         mem_io_oe_ff,          // Memory/IO drive enable
  output reg         wr_rd_o_ff,            // Write/read drive value
  output reg         wr_rd_oe_ff,           // Write/read drive enable
  output reg         upper_byte_enable_o_ff,   // Upper byte drive value
  output reg         upper_byte_enable_oe_ff,  // Upper byte drive enable
  output reg         maskable_interrupt_request_ff, // Interrupt request
  output reg         nmi_ff,                // Non-maskable interrupt
  output reg         processor_reset_ff,    // Processor reset
  output wire        processor_clock_o,     // Processor clock value
  output wire        processor_clock_oe,    // Processor clock drive enable
  output reg         cyc_mem_ff,            // Last cycle was memory
  output reg         cyc_write_ff,          // Last cycle was write
  output reg         cyc_data_ff,           // Last cycle was data
  output reg         cyc_upper_ff           // Last cycle used upper byte
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_DONE = 2'h2;
  localparam HS_IDLE = 2'h0;
  localparam HS_REQ  = 2'h1;
  localparam HS_OWN  = 2'h2;
  localparam HS_REL  = 2'h3;

  reg [1:0]        st_ff, nxt_st;
  reg [WAIT_W-1:0] wcnt_ff, nxt_wcnt;
  reg              smi_cyc_ff, nxt_smi_cyc;
  reg [1:0]        hs_ff, nxt_hs;
  reg [7:0]        rst_cnt_ff;
  wire             smi_on    = smi_cfg[`PLBC_SMI_EN_BIT]; // R19
  // Strobe only counts between cycles and while the processor owns the bus
  wire             start     = ~cycle_start_strobe_n & ~bus_hold_grant; // R6
  wire             wait_zero = (wcnt_ff == {WAIT_W{1'b0}});
  wire             done      = (st_ff == ST_WAIT) && wait_zero && local_ready;
  // SMI cycle that must be answered on the dedicated ready line
  wire             sep_smi   = smi_cyc_ff & (smi_mode == `PLBC_SMIMODE_SEP); // R2 R11

  plbc_clk_gen u_clk (
    .clk        (clk),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .clk_ctl    (clk_ctl),
    .pclk_o_ff  (processor_clock_o),
    .pclk_oe_ff (processor_clock_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Processor cycle tracking
  always @* begin
    nxt_st      = st_ff;
    nxt_wcnt    = wcnt_ff;
    nxt_smi_cyc = smi_cyc_ff;
    case (st_ff)
      ST_IDLE: begin
        if (start) begin // R6
          nxt_st      = ST_WAIT;
          nxt_wcnt    = wait_states;
          nxt_smi_cyc = smi_on & ~smi_space_strobe_n; // R7
        end
      end
      ST_WAIT: begin
        if (wcnt_ff != {WAIT_W{1'b0}})
          nxt_wcnt = wcnt_ff - {{(WAIT_W-1){1'b0}}, 1'b1};
        else if (local_ready)
          nxt_st = ST_DONE;
      end
      // One idle edge after ready keeps back-to-back strobes apart
      ST_DONE: nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff        <= ST_IDLE;
      wcnt_ff      <= {WAIT_W{1'b0}};
      smi_cyc_ff   <= 1'b0;
      cyc_mem_ff   <= 1'b0;
      cyc_write_ff <= 1'b0;
      cyc_data_ff  <= 1'b0;
      cyc_upper_ff <= 1'b0;
      ready_n_ff   <= 1'b1;
      smi_cycle_done_n_ff        <= 1'b1;
      pipeline_next_address_n_ff <= 1'b1;
    end else if (clk_en) begin
      st_ff      <= nxt_st;
      wcnt_ff    <= nxt_wcnt;
      smi_cyc_ff <= nxt_smi_cyc;
      if (st_ff == ST_IDLE && start) begin
        cyc_mem_ff   <= mem_io_i;                // R4
        cyc_write_ff <= wr_rd_i;                 // R8
        cyc_data_ff  <= data_ctl_i;              // R3
        cyc_upper_ff <= ~upper_byte_enable_n_i;  // R1
      end
      // Separate SMI ready only in separate mode; else normal ready serves both
      ready_n_ff <= ~(done & ~sep_smi); // R10 R11
      smi_cycle_done_n_ff <= ~(done & sep_smi); // R2
      pipeline_next_address_n_ff <= ~(pipeline_en && st_ff == ST_WAIT && wait_zero); // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus hold handshake and DMA cycle drive
  always @* begin
    nxt_hs = hs_ff;
    case (hs_ff)
      // Ask for the bus only between processor cycles
      HS_IDLE: if (dma_req && st_ff == ST_IDLE) nxt_hs = HS_REQ;
      HS_REQ:  if (bus_hold_grant) nxt_hs = HS_OWN; // R13
      HS_OWN:  if (!dma_req) nxt_hs = HS_REL;
      HS_REL:  nxt_hs = HS_IDLE;
      default: nxt_hs = HS_IDLE;
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_ff                   <= HS_IDLE;
      bus_hold_request_ff     <= 1'b0;
      cycle_start_strobe_o_ff <= 1'b1;
      cycle_start_strobe_oe_ff <= 1'b0;
      mem_io_o_ff             <= 1'b0;
      mem_io_oe_ff            <= 1'b0;
      wr_rd_o_ff              <= 1'b0;
      wr_rd_oe_ff             <= 1'b0;
      upper_byte_enable_o_ff  <= 1'b1;
      upper_byte_enable_oe_ff <= 1'b0;
    end else if (clk_en) begin
      hs_ff <= nxt_hs;
      // Request held through release so drivers drop first
      bus_hold_request_ff <= (nxt_hs != HS_IDLE); // R12 R21
      cycle_start_strobe_oe_ff <= (nxt_hs == HS_OWN) & snoop_en; // R5 R21
      cycle_start_strobe_o_ff  <= ~((nxt_hs == HS_OWN) & dma_mem & dma_write);
      mem_io_oe_ff <= (nxt_hs == HS_OWN) & snoop_en; // R5 R21
      mem_io_o_ff  <= dma_mem;
      wr_rd_oe_ff  <= (nxt_hs == HS_OWN) & cached_cpu & dma_mem & dma_write; // R9 R21
      wr_rd_o_ff   <= dma_write;
      upper_byte_enable_oe_ff <= (nxt_hs == HS_OWN); // R1 R21
      upper_byte_enable_o_ff  <= ~dma_upper;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts and processor reset
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      maskable_interrupt_request_ff <= 1'b0;
      nmi_ff                        <= 1'b0;
      processor_reset_ff            <= 1'b1;
      rst_cnt_ff                    <= `PLBC_RST_CYC;
    end else if (clk_en) begin
      maskable_interrupt_request_ff <= irq_req; // R17
      // Channel check is active low and raises the same NMI
      nmi_ff <= nmi_req | ~channel_check_n; // R15 R20
      // Reset stays up for a fixed stretch after release or a request
      if (sw_reset)
        rst_cnt_ff <= `PLBC_RST_CYC;
      else if (rst_cnt_ff != 8'h00)
        rst_cnt_ff <= rst_cnt_ff - 8'h01;
      processor_reset_ff <= sw_reset | (rst_cnt_ff != 8'h00); // R18
    end
  end
endmodule // plbc_top
